// *** rtl/adcrc_bus_end.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcrc_bus_end
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor side
  input wire logic [1:0] mode,
  input wire logic rd_hi_req,
  input wire logic rd_lo_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic frozen,
  // link
  adcrc_if.bus_end lnk
);
  // freeze state of the coherency logic, one-hot
  typedef enum logic [1:0]
  {
    ADCRC_ST_LIVE = 2'h1,
    ADCRC_ST_FROZEN = 2'h2
  } adcrc_frz_t;

  // held result and the low byte kept for a pending pair
  logic [11:0] live_r;
  logic [11:0] live_nxt;
  logic [7:0] lo_hold_r;
  logic [7:0] lo_hold_nxt;
  // freeze state
  adcrc_frz_t st_r;
  adcrc_frz_t st_nxt;
  // read answer towards the processor
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic vld_r;
  logic vld_nxt;
  // decoded mode and requests
  logic coh;
  logic frz;
  logic hi_take;
  logic lo_take;
  logic race;
  // byte views of the held result
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;

  // high byte of a result for a mode, unused bits zero
  function automatic logic [7:0] hi_of(input logic [1:0] m,
                                       input logic [11:0] r);
    logic [7:0] raw;
    raw = adcrc_pkg::BYTE_ZERO;
    raw[adcrc_pkg::HI_W-1:0] = r[adcrc_pkg::RES_W-1:adcrc_pkg::BYTE_W];
    unique case (m)
      adcrc_pkg::ADCRC_MODE_10: hi_of = raw & adcrc_pkg::HI_MASK_10;
      adcrc_pkg::ADCRC_MODE_12: hi_of = raw & adcrc_pkg::HI_MASK_12;
      default: hi_of = adcrc_pkg::HI_MASK_8;
    endcase
  endfunction

  // true in the modes whose result spans two bytes
  function automatic logic is_two_byte(input logic [1:0] m);
    is_two_byte = (m == adcrc_pkg::ADCRC_MODE_10) ||
                  (m == adcrc_pkg::ADCRC_MODE_12);
  endfunction

  // low byte of a raw result
  function automatic logic [7:0] lo_of(input logic [11:0] r);
    lo_of = r[adcrc_pkg::BYTE_W-1:0];
  endfunction

  // request decode; a high read wins when both strobes come together
  assign coh = is_two_byte(mode);
  assign frz = (st_r == ADCRC_ST_FROZEN);
  assign hi_take = rd_hi_req;
  assign lo_take = rd_lo_req && !rd_hi_req;
  // completion landing on the cycle of the freezing high read
  assign race = lnk.done && hi_take && coh && !frz;

  // byte views; the low byte comes from the hold while frozen
  assign hi_byte = hi_of(mode, live_r);
  assign lo_byte = frz ? lo_hold_r : lo_of(live_r);

  // freeze state: set by a high read, cleared by the low read
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ADCRC_ST_LIVE:
      begin
        // high read in a two-byte mode freezes the pair
        if (hi_take && coh)
          st_nxt = ADCRC_ST_FROZEN;
      end
      ADCRC_ST_FROZEN:
      begin
        // only the low read lets the next result through
        if (lo_take)
          st_nxt = ADCRC_ST_LIVE;
      end
      default:
      begin
        // illegal code, fall back to the live state
        st_nxt = ADCRC_ST_LIVE;
      end
    endcase
    // single-byte mode never freezes
    if (!coh)
      st_nxt = ADCRC_ST_LIVE;
  end

  // register the freeze state
  always_ff @(posedge clk)
  begin
    if (rst)
      st_r <= ADCRC_ST_LIVE;
    else
      st_r <= st_nxt;
  end

  // result capture; a completion never splits a pair
  always_comb
  begin
    live_nxt = live_r;
    lo_hold_nxt = lo_hold_r;
    if (lnk.done)
    begin
      // live: the new result goes straight in
      if (!frz && !race)
        live_nxt = lnk.result;
      // releasing low read: taken for the next pair
      else if (frz && lo_take)
        live_nxt = lnk.result;
      // frozen or racing: dropped, the pair stays whole
      else
        live_nxt = live_r;
    end
    // the freezing high read keeps the low byte of the held result
    if (hi_take && coh && !frz)
      lo_hold_nxt = lo_of(live_r);
  end

  // register the held result and the kept low byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      live_r <= adcrc_pkg::RES_ZERO;
      lo_hold_r <= adcrc_pkg::BYTE_ZERO;
    end
    else
    begin
      live_r <= live_nxt;
      lo_hold_r <= lo_hold_nxt;
    end
  end

  // read answer: one valid pulse per taken read
  always_comb
  begin
    data_nxt = data_r;
    vld_nxt = 1'b0;
    if (hi_take)
    begin
      // single-byte mode has no high byte to return
      data_nxt = coh ? hi_byte : adcrc_pkg::BYTE_ZERO;
      vld_nxt = 1'b1;
    end
    else if (lo_take)
    begin
      // kept low byte while frozen in two-byte modes, plain byte otherwise
      data_nxt = coh ? lo_byte : lo_of(live_r);
      vld_nxt = 1'b1;
    end
  end

  // register the read answer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_r <= adcrc_pkg::BYTE_ZERO;
      vld_r <= 1'b0;
    end
    else
    begin
      data_r <= data_nxt;
      vld_r <= vld_nxt;
    end
  end

  // read strobes to the link mirror processor reads
  assign lnk.rd_hi = rd_hi_req;
  assign lnk.rd_lo = rd_lo_req;
  // outputs from the registers
  assign rd_data = data_r;
  assign rd_valid = vld_r;
  assign frozen = frz;
endmodule
`default_nettype wire

// *** rtl/adcrc_pkg.sv ***
package adcrc_pkg;
  // result widths
  localparam int RES_W = 12;
  localparam int BYTE_W = 8;
  localparam int HI_W = RES_W - BYTE_W;
  // result mode encoding
  typedef enum logic [1:0]
  {
    ADCRC_MODE_8 = 2'h0,
    ADCRC_MODE_10 = 2'h1,
    ADCRC_MODE_12 = 2'h2
  } adcrc_mode_t;
  // valid bits of the high byte per mode
  localparam logic [7:0] HI_MASK_10 = 8'h03;
  localparam logic [7:0] HI_MASK_12 = 8'h0F;
  localparam logic [7:0] HI_MASK_8 = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] RES_ZERO = 12'h000;
endpackage

// *** rtl/adcrc_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface adcrc_if;
  // conversion complete strobe and raw result from the core
  logic done;
  logic [11:0] result;
  // byte reads from the bus side
  logic rd_hi;
  logic rd_lo;
  modport core_end (output done, output result, input rd_hi, input rd_lo);
  modport bus_end (input done, input result, output rd_hi, output rd_lo);
endinterface
`default_nettype wire

// *** rtl/adcrc_core_end.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcrc_core_end
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user side: finished conversion
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  // link
  adcrc_if.core_end lnk
);
  logic done_r, done_nxt;
  logic [11:0] res_r, res_nxt;

  // pass completed conversions to the coherency logic one cycle later, done high for every cycle of conv_done
  always_comb
  begin
    done_nxt = conv_done;
    res_nxt = conv_done ? conv_result : res_r;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_r <= 1'b0;
      res_r <= adcrc_pkg::RES_ZERO;
    end
    else
    begin
      done_r <= done_nxt;
      res_r <= res_nxt;
    end
  end

  assign lnk.done = done_r;
  assign lnk.result = res_r;
endmodule
`default_nettype wire

// *** bench/adcrc_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcrc_asserts
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic done,
  input wire logic [11:0] result,
  input wire logic rd_hi,
  input wire logic rd_lo,
  // processor side of the bus end
  input wire logic [1:0] mode,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic frozen
);
  // two-byte result modes
  logic two_b;
  assign two_b = (mode == adcrc_pkg::ADCRC_MODE_10) ||
                 (mode == adcrc_pkg::ADCRC_MODE_12);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // result moves only with a completion
  property p_res_hold;
    !done |-> $stable(result);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("result moved without done");
  // completion is one pulse
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held");
  // every taken read is answered on the next edge
  property p_rd_answer;
    (rd_hi || rd_lo) |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  // high read in a two-byte mode freezes the pair
  property p_frz_set;
    (rd_hi && two_b) |=> frozen;
  endproperty
  a_frz_set: assert property (p_frz_set)
    else $error("high read did not freeze");
  // freeze stands until the low read, completions included
  property p_frz_hold;
    (frozen && two_b && !rd_lo) |=> frozen;
  endproperty
  a_frz_hold: assert property (p_frz_hold)
    else $error("freeze lost before low read");
  // low read releases the freeze
  property p_release;
    (frozen && rd_lo && !rd_hi) |=> !frozen;
  endproperty
  a_release: assert property (p_release)
    else $error("low read did not release");
  // single-byte mode: no freeze
  property p_byte_nofrz;
    ($past(mode) == adcrc_pkg::ADCRC_MODE_8) |-> !frozen;
  endproperty
  a_byte_nofrz: assert property (p_byte_nofrz)
    else $error("freeze in single-byte mode");
  // single-byte mode: high read returns an empty byte
  property p_byte_hi;
    (rd_valid && $past(rd_hi) && ($past(mode) == adcrc_pkg::ADCRC_MODE_8))
      |-> (rd_data == adcrc_pkg::BYTE_ZERO);
  endproperty
  a_byte_hi: assert property (p_byte_hi)
    else $error("high byte not empty in single-byte mode");
  // race, pair, release and single-byte low read reached
  c_race: cover property (done && rd_hi);
  c_pair: cover property (rd_hi ##[1:6] rd_lo);
  c_release: cover property (frozen && rd_lo);
  c_byte: cover property (rd_lo && (mode == adcrc_pkg::ADCRC_MODE_8));
endmodule
`default_nettype wire

// *** bench/tb_adc_result_coherency.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_adc_result_coherency;
  logic clk = 1'b0, rst = 1'b1, conv_done = 1'b0;
  logic rd_hi_req = 1'b0, rd_lo_req = 1'b0, rd_valid, frozen;
  logic [11:0] conv_result = 12'h000;
  logic [1:0] mode = 2'h0;
  logic [7:0] rd_data;
  int errors = 0, total_checks = 0;
  adcrc_if lnk ();
  adcrc_core_end i_adcrc_core_end (.clk(clk), .rst(rst),
    .conv_done(conv_done), .conv_result(conv_result), .lnk(lnk));
  adcrc_bus_end i_adcrc_bus_end (.clk(clk), .rst(rst), .mode(mode),
    .rd_hi_req(rd_hi_req), .rd_lo_req(rd_lo_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .frozen(frozen), .lnk(lnk));
  adcrc_asserts i_adcrc_asserts (.clk(clk), .rst(rst), .done(lnk.done),
    .result(lnk.result), .rd_hi(lnk.rd_hi), .rd_lo(lnk.rd_lo),
    .mode(mode), .rd_data(rd_data), .rd_valid(rd_valid), .frozen(frozen));
  // clock
  initial forever #5 clk = ~clk;
  // compare and report
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) errors++;
    if (seen !== exp) $display("[FAIL] %0t %h %h", $time, seen, exp);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one completion from the core
  task conv(input logic [11:0] v);
    @(negedge clk) conv_done = 1'b1;
    conv_result = v;
    @(negedge clk) conv_done = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // one byte read, bounded wait for the answer
  task rd(input logic hi, input logic [7:0] exp);
    int n;
    @(negedge clk) conv_done = 1'b0;
    rd_hi_req = hi;
    rd_lo_req = ~hi;
    @(negedge clk) rd_hi_req = 1'b0;
    rd_lo_req = 1'b0;
    for (n = 0; n < 4 && rd_valid !== 1'b1; n++) @(negedge clk);
    if (n == 4) errors++;
    if (n == 4) wrap_up();
    chk(rd_data, exp);
  endtask
  // 12-bit pair, completion dropped while frozen, then release
  task t_pair;
    mode = adcrc_pkg::ADCRC_MODE_12;
    conv(12'hABC);
    rd(1'b1, 8'h0A);
    chk({7'h00, frozen}, 8'h01);
    conv(12'h123);
    rd(1'b0, 8'hBC);
    chk({7'h00, frozen}, 8'h00);
    conv(12'h456);
    rd(1'b1, 8'h04);
    rd(1'b0, 8'h56);
  endtask
  // 10-bit high read in the completion cycle
  task t_race;
    mode = adcrc_pkg::ADCRC_MODE_10;
    conv(12'h2F5);
    @(negedge clk) conv_done = 1'b1;
    conv_result = 12'h1AA;
    rd(1'b1, 8'h02);
    chk({7'h00, frozen}, 8'h01);
    rd(1'b0, 8'hF5);
  endtask
  // 8-bit mode: no freeze
  task t_byte;
    mode = adcrc_pkg::ADCRC_MODE_8;
    conv(12'h3C7);
    rd(1'b1, 8'h00);
    chk({7'h00, frozen}, 8'h00);
    conv(12'h0D9);
    rd(1'b0, 8'hD9);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_pair();
    t_race();
    t_byte();
    wrap_up();
  end
endmodule
`default_nettype wire
